// ==== hw/branch_and_bitset_exec.sv ====
// Decode and execute for relative branches and the file bit-set instruction
`timescale 1ns/100ps
module branch_and_bitset_exec (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] instr,
   input wire logic instr_valid,
   input wire logic [branch_bitset_pkg::PC_WIDTH-1:0] pc_inc,
   input wire logic [7:0] status,
   input wire logic [branch_bitset_pkg::BANK_WIDTH-1:0] bank_select_reg,
   input wire logic [7:0] file_rdata,
   output logic [1:0] q_phase,
   output logic [11:0] file_addr,
   output logic file_rd,
   output logic file_wr,
   output logic [7:0] file_wdata,
   output logic pc_load,
   output logic [branch_bitset_pkg::PC_WIDTH-1:0] pc_target,
   output logic flush,
   output logic busy
);
   typedef enum logic [1:0] {
      ST_EXEC = 2'b00,
      ST_NOP = 2'b01
   } cyc_e;

   cyc_e state;
   cyc_e next_state;
   logic [2:0] bit_pos;
   logic [branch_bitset_pkg::PC_WIDTH-1:0] next_target;

   // The doubled 11-bit offset needs at least this PC width; the bank mux needs exactly four bank bits
   if (branch_bitset_pkg::PC_WIDTH < 13) begin : g_pc_width_check
      $error("pc width too narrow for a doubled 11-bit offset");
   end
   if (branch_bitset_pkg::BANK_WIDTH != 4) begin : g_bank_width_check
      $error("bank register must be four bits wide");
   end

   // Decode, qualified by a live instruction word
   wire live = instr_valid && state == ST_EXEC;
   wire dec_nov = live && instr[15:8] == branch_bitset_pkg::OP_BRANCH_NO_OVERFLOW;
   wire dec_nz = live && instr[15:8] == branch_bitset_pkg::OP_BRANCH_NONZERO;
   wire dec_nn = live && instr[15:8] == branch_bitset_pkg::OP_BRANCH_NON_NEGATIVE;
   wire dec_bra = live && instr[15:11] == branch_bitset_pkg::OP_BRANCH_ALWAYS;
   wire dec_bsf = live && instr[15:12] == branch_bitset_pkg::OP_SET_FILE_BIT;
   wire take_nov = dec_nov && !status[branch_bitset_pkg::STATUS_OVERFLOW];
   wire take_nz = dec_nz && !status[branch_bitset_pkg::STATUS_ZERO];
   wire take_nn = dec_nn && !status[branch_bitset_pkg::STATUS_NEGATIVE];
   wire taken = take_nov || take_nz || take_nn || dec_bra;

   // Offsets sign extended, then doubled; wraps at the PC width
   wire [branch_bitset_pkg::PC_WIDTH-1:0] off8 =
      {{(branch_bitset_pkg::PC_WIDTH-9){instr[7]}}, instr[7:0], 1'b0};
   wire [branch_bitset_pkg::PC_WIDTH-1:0] off11 =
      {{(branch_bitset_pkg::PC_WIDTH-12){instr[10]}}, instr[10:0], 1'b0};
   wire [branch_bitset_pkg::PC_WIDTH-1:0] calc_target =
      pc_inc + (dec_bra ? off11 : off8);

   // Access bank: low half is bank 0, high half is the top bank
   wire [3:0] access_bank = instr[7:0] >= branch_bitset_pkg::ACCESS_SPLIT ?
      branch_bitset_pkg::ACCESS_HIGH_BANK : 4'h0;
   wire [3:0] op_bank = instr[branch_bitset_pkg::BANK_SEL_BIT] ?
      4'(bank_select_reg) : access_bank;
   wire [11:0] op_addr = {op_bank, instr[7:0]};
   wire [7:0] set_mask = 8'h01 << bit_pos;

   // Only Q4 moves the state, so the dead cycle is always four whole quarters
   always_comb begin
      next_state = ST_EXEC;
      if (q_phase == 2'h3) begin
         next_state = taken ? ST_NOP : ST_EXEC;
      end else begin
         next_state = state;
      end
   end

   assign next_target = calc_target;

   // Quarter counter runs freely; instructions align to it, never the reverse
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q_phase <= branch_bitset_pkg::Q_RESET;
      end else begin
         q_phase <= q_phase + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_EXEC;
         bit_pos <= 3'h0;
         file_addr <= 12'h000;
      end else begin
         state <= next_state;
         if (q_phase == 2'h0 && dec_bsf) begin
            bit_pos <= instr[branch_bitset_pkg::BIT_POS_LSB +: 3];
            file_addr <= op_addr;
         end
      end
   end

   // Q2 read, Q3 modify, Q4 write: one instruction cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         file_rd <= 1'b0;
         file_wr <= 1'b0;
         file_wdata <= 8'h00;
      end else begin
         file_rd <= q_phase == 2'h0 && dec_bsf;
         // Read data is only trusted in Q3, one quarter after the read strobe
         if (q_phase == 2'h2 && dec_bsf) begin
            file_wdata <= file_rdata | set_mask;
         end
         file_wr <= q_phase == 2'h2 && dec_bsf;
      end
   end

   // Status flags are never written here; no flag output exists
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_load <= 1'b0;
         pc_target <= '0;
         flush <= 1'b0;
         busy <= 1'b0;
      end else begin
         pc_load <= q_phase == 2'h2 && taken;
         // Held after the load, so the fetch side may take it late
         if (q_phase == 2'h2 && taken) begin
            pc_target <= next_target;
         end
         flush <= q_phase == 2'h2 && taken;
         // From next_state, so busy is already up in the first dead quarter
         busy <= next_state == ST_NOP;
      end
   end

   // Pulses are checked against the quarter count, which no instruction can stall
   a_set_writes_bit: assert property (@(posedge clk) disable iff (!rst_b)
      file_wr |-> file_wdata[bit_pos] && file_wdata == ($past(file_rdata) | set_mask))
      else $error("bit-set wrote wrong data");
   a_load_in_q4: assert property (@(posedge clk) disable iff (!rst_b)
      pc_load |-> q_phase == 2'h3 && flush)
      else $error("pc load outside Q4");
   a_nop_cycle_after: assert property (@(posedge clk) disable iff (!rst_b)
      pc_load |=> state == ST_NOP [*4] ##1 state == ST_EXEC)
      else $error("taken branch did not last two cycles");
   a_target_sum: assert property (@(posedge clk) disable iff (!rst_b)
      q_phase == 2'h2 && taken |=> pc_target == $past(calc_target))
      else $error("branch target wrong");
   a_bra_always: assert property (@(posedge clk) disable iff (!rst_b)
      q_phase == 2'h2 && dec_bra |=> pc_load)
      else $error("unconditional branch not taken");
   a_nov_cond: assert property (@(posedge clk) disable iff (!rst_b)
      q_phase == 2'h2 && dec_nov && status[branch_bitset_pkg::STATUS_OVERFLOW]
      && !dec_bra |=> !pc_load)
      else $error("overflow branch taken with flag set");
   a_nz_cond: assert property (@(posedge clk) disable iff (!rst_b)
      q_phase == 2'h2 && dec_nz |=>
      pc_load == !$past(status[branch_bitset_pkg::STATUS_ZERO]))
      else $error("nonzero branch decision wrong");
   a_nn_cond: assert property (@(posedge clk) disable iff (!rst_b)
      q_phase == 2'h2 && dec_nn |=>
      pc_load == !$past(status[branch_bitset_pkg::STATUS_NEGATIVE]))
      else $error("non-negative branch decision wrong");
   a_bank_access: assert property (@(posedge clk) disable iff (!rst_b)
      q_phase == 2'h0 && dec_bsf && !instr[branch_bitset_pkg::BANK_SEL_BIT]
      |=> file_addr[11:8] == $past(access_bank))
      else $error("access bank not used");
   a_bank_reg: assert property (@(posedge clk) disable iff (!rst_b)
      q_phase == 2'h0 && dec_bsf && instr[branch_bitset_pkg::BANK_SEL_BIT]
      |=> file_addr[11:8] == $past(4'(bank_select_reg)))
      else $error("bank register not used");
   a_access_split: assert property (@(posedge clk) disable iff (!rst_b)
      q_phase == 2'h0 && dec_bsf && !instr[branch_bitset_pkg::BANK_SEL_BIT] |=>
      file_addr[11:8] == ($past(instr[7]) ? branch_bitset_pkg::ACCESS_HIGH_BANK : 4'h0))
      else $error("access bank split wrong");
   a_flush_with_load: assert property (@(posedge clk) disable iff (!rst_b)
      flush == pc_load)
      else $error("flush and pc load out of step");
   a_load_single: assert property (@(posedge clk) disable iff (!rst_b)
      pc_load |=> !pc_load)
      else $error("pc load longer than one quarter");
   a_busy_length: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(busy) |-> busy [*4] ##1 !busy)
      else $error("dead cycle not four quarters");
   a_nop_quiet: assert property (@(posedge clk) disable iff (!rst_b)
      state == ST_NOP |-> !file_rd && !file_wr && !pc_load)
      else $error("activity in the dead cycle");
   a_not_taken_short: assert property (@(posedge clk) disable iff (!rst_b)
      q_phase == 2'h2 && (dec_nov || dec_nz || dec_nn) && !taken |=> !pc_load ##1 !busy)
      else $error("untaken branch stretched");
   a_rd_in_q2: assert property (@(posedge clk) disable iff (!rst_b)
      file_rd |-> q_phase == 2'h1 ##2 file_wr)
      else $error("read and write not in Q2 and Q4");
   a_wr_single: assert property (@(posedge clk) disable iff (!rst_b)
      file_wr |=> !file_wr && !file_rd)
      else $error("write longer than one quarter");

   // Main scenarios that the bench is expected to reach
   c_taken: cover property (@(posedge clk) disable iff (!rst_b) pc_load && !dec_bra);
   c_bra: cover property (@(posedge clk) disable iff (!rst_b) q_phase == 2'h2 && dec_bra);
   c_not_taken: cover property (@(posedge clk) disable iff (!rst_b)
      q_phase == 2'h2 && dec_nz && !taken);
   c_bitset: cover property (@(posedge clk) disable iff (!rst_b) file_wr);
   c_dead_cycle_offer: cover property (@(posedge clk) disable iff (!rst_b)
      busy && instr_valid);
endmodule

// ==== hw/branch_bitset_pkg.sv ====
// Constants for the branch and bit-set execute block
package branch_bitset_pkg;
   localparam int PC_WIDTH = 21;
   localparam int BANK_WIDTH = 4;
   localparam logic [7:0] OP_BRANCH_NO_OVERFLOW = 8'he5;
   localparam logic [7:0] OP_BRANCH_NONZERO = 8'he1;
   localparam logic [7:0] OP_BRANCH_NON_NEGATIVE = 8'he7;
   localparam logic [4:0] OP_BRANCH_ALWAYS = 5'h1a;
   localparam logic [3:0] OP_SET_FILE_BIT = 4'h8;
   localparam int BIT_POS_LSB = 9;
   localparam int BANK_SEL_BIT = 8;
   localparam int STATUS_ZERO = 2;
   localparam int STATUS_OVERFLOW = 3;
   localparam int STATUS_NEGATIVE = 4;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
   localparam logic [1:0] Q_RESET = 2'h0;
endpackage

// ==== testbench/branch_and_bitset_exec_test.sv ====
// Self-checking bench for the branch and bit-set execute block
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module branch_and_bitset_exec_test;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic instr_valid = 1'b0;
   logic [20:0] pc_inc = 21'h012344;
   logic [7:0] status = 8'h00;
   logic [3:0] bank_select_reg = 4'h0;
   logic [7:0] file_rdata = 8'h00;
   logic [1:0] q_phase;
   logic [11:0] file_addr;
   logic [7:0] file_wdata;
   logic [20:0] pc_target;
   logic file_rd, file_wr, pc_load, flush, busy;
   int n_mismatch = 0;
   int tests_run = 0;
   always #2.5 clk = ~clk;
   branch_and_bitset_exec dut (.clk(clk), .rst_b(rst_b), .instr(instr),
      .instr_valid(instr_valid), .pc_inc(pc_inc), .status(status),
      .bank_select_reg(bank_select_reg), .file_rdata(file_rdata), .q_phase(q_phase),
      .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr), .file_wdata(file_wdata),
      .pc_load(pc_load), .pc_target(pc_target), .flush(flush), .busy(busy));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Presents a word for a whole cycle; returns settled in Q2
   task automatic issue(input logic [15:0] w, input logic [7:0] st, input logic [3:0] bk,
         input logic [7:0] rd);
      // Look after the edge, so the next edge starts a fresh Q1
      do step(1); while (q_phase !== 2'h3);
      @(posedge clk);
      instr <= w;
      instr_valid <= 1'b1;
      status <= st;
      bank_select_reg <= bk;
      file_rdata <= rd;
      step(1);
      `CHK(q_phase, 2'h1)
   endtask
   task automatic chk_branch(input logic [15:0] w, input logic [7:0] st, input logic tk,
         input logic [20:0] exp);
      issue(w, st, 4'h5, 8'h00);
      step(2);
      `CHK(pc_load, tk)
      `CHK(flush, tk)
      if (tk) `CHK(pc_target, exp)
      @(posedge clk);
      // A word offered in the dead cycle must not start a file access
      instr <= 16'h8000;
      instr_valid <= tk;
      for (int i = 0; i < 4; i++) begin
         #1;
         `CHK(busy, tk)
         `CHK(file_rd | file_wr | pc_load, 1'b0)
         @(posedge clk);
      end
      instr_valid <= 1'b0;
   endtask
   task automatic t_cond_branches();
      logic [7:0] op [3] = '{8'he5, 8'he1, 8'he7};
      int fl [3] = '{3, 2, 4};
      for (int k = 0; k < 3; k++) begin
         chk_branch({op[k], 8'h7f}, 8'h00, 1'b1, pc_inc + 21'h0000fe);
         chk_branch({op[k], 8'h80}, 8'h01 << fl[k], 1'b0, pc_inc);
         chk_branch({op[k], 8'h80}, ~(8'h01 << fl[k]), 1'b1, pc_inc - 21'h100);
      end
   endtask
   task automatic t_always_branch();
      chk_branch({5'h1a, 11'h3ff}, 8'hff, 1'b1, pc_inc + 21'h0007fe);
      chk_branch({5'h1a, 11'h400}, 8'hff, 1'b1, pc_inc - 21'h000800);
   endtask
   task automatic set_bit(input logic [2:0] b, input logic a, input logic [7:0] f,
         input logic [3:0] bk, input logic [7:0] rd, input logic [11:0] ea);
      issue({4'h8, b, a, f}, 8'h00, bk, rd);
      `CHK(file_rd, 1'b1)
      `CHK(file_addr, ea)
      step(1);
      `CHK(file_rd, 1'b0)
      step(1);
      `CHK(file_wr, 1'b1)
      `CHK(file_wdata, rd | (8'h01 << b))
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      `CHK(file_wr | busy, 1'b0)
   endtask
   task automatic t_set_bits();
      set_bit(3'h7, 1'b1, 8'h34, 4'h5, 8'h0a, 12'h534);
      set_bit(3'h0, 1'b0, 8'h7f, 4'h5, 8'hfe, 12'h07f);
      set_bit(3'h3, 1'b0, 8'h80, 4'h5, 8'h80, 12'hf80);
      set_bit(3'h4, 1'b1, 8'hff, 4'h2, 8'hef, 12'h2ff);
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_cond_branches();
      t_always_branch();
      t_set_bits();
      report_and_stop();
   end
endmodule
